// *** rtl/lsbwd_pkg.sv ***
/*
  Shared constants and types for the mode and window watchdog block.
  Assumes a 20 MHz system clock and a 51 kilo-ohm watchdog timing resistor.
*/
package lsbwd_pkg;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int WDT_RES_KOHM = 51;
  // Oscillator period in ns: 405*R - 0.4*R*R, R in kilo-ohms.
  localparam int WDT_OSC_PERIOD_NS = 405 * WDT_RES_KOHM - (4 * WDT_RES_KOHM * WDT_RES_KOHM) / 10;
  localparam int WDT_OSC_CYC = WDT_OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LEAD_TIME_MS = 155;
  localparam int LEAD_OSC = int'((longint'(LEAD_TIME_MS) * 64'd1000000) / WDT_OSC_PERIOD_NS);
  localparam int CLOSED_OSC = 527;
  localparam int OPEN_OSC = 490;
  localparam int RSTPULSE_OSC = 200;
  localparam int DOM_TIMEOUT_US = 10000;
  localparam int DOM_CYC = (DOM_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h0C;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h10;
  localparam int STATUS_MODE_LSB = 0;
  localparam int STATUS_WDT_LSB = 4;
  localparam int STATUS_PIN_BIT = 9;
  localparam int STATUS_TXDF_BIT = 10;
  localparam int CTRL_WAKE_BIT = 0;
  localparam int EV_TIMEOUT = 0;
  localparam int EV_EARLY = 1;
  localparam int EV_DOM = 2;
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] IRQ_RESET = 3'h0;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [3:0] {
    MODE_FAILSAFE = 4'h1,
    MODE_NORMAL = 4'h2,
    MODE_SILENT = 4'h4,
    MODE_SLEEP = 4'h8
  } lsbwd_mode_t;

  typedef enum logic [4:0] {
    WDT_OFF = 5'h01,
    WDT_LEAD = 5'h02,
    WDT_CLOSED = 5'h04,
    WDT_OPEN = 5'h08,
    WDT_RESET = 5'h10
  } lsbwd_wdt_state_t;

  typedef struct packed {
    logic timeout;
    logic early;
  } lsbwd_wdt_ev_t;

  typedef struct packed {
    lsbwd_wdt_state_t state;
    logic reset_active;
  } lsbwd_wdt_stat_t;

endpackage

// *** rtl/lsbwd_tick.sv ***
/*
  Watchdog oscillator model: one tick per oscillator period.
  Assumes the run input drops when the watchdog is halted.
*/
`timescale 1ns/1ps
`default_nettype none

module lsbwd_tick #(
  parameter int unsigned DIV = 392
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  output logic o_tick
);

  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt;

  if (DIV < 1) begin : g_bad_div
    $error("lsbwd_tick: DIV must be at least 1");
  end

  // The divider restarts from zero whenever the oscillator is stopped.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= '0;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      cnt <= '0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= (cnt == LAST);
      cnt <= (cnt == LAST) ? '0 : cnt + CW'(1);
    end
  end

endmodule

`default_nettype wire

// *** rtl/lsbwd_wdt.sv ***
/*
  Window watchdog sequencer counting oscillator ticks.
  Assumes i_trig_fall is a one-cycle pulse per falling trigger edge.
*/
`timescale 1ns/1ps
`default_nettype none

module lsbwd_wdt #(
  parameter int unsigned LEAD_OSC = 7902,
  parameter int unsigned CLOSED_OSC = 527,
  parameter int unsigned OPEN_OSC = 490,
  parameter int unsigned RSTPULSE_OSC = 200,
  parameter int unsigned CW = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic i_trig_fall,
  output lsbwd_pkg::lsbwd_wdt_stat_t o_stat,
  output lsbwd_pkg::lsbwd_wdt_ev_t o_ev
);

  lsbwd_pkg::lsbwd_wdt_state_t state;
  logic [CW-1:0] cnt;

  if (LEAD_OSC < 1 || CLOSED_OSC < 1 || OPEN_OSC < 1 || RSTPULSE_OSC < 1
      || LEAD_OSC >= 2 ** CW || CLOSED_OSC >= 2 ** CW || OPEN_OSC >= 2 ** CW
      || RSTPULSE_OSC >= 2 ** CW) begin : g_bad_len
    $error("lsbwd_wdt: interval lengths must be 1 .. 2**CW-1");
  end

  function automatic logic at_end(input logic [CW-1:0] c, input int unsigned len);
    return c == CW'(len - 1);
  endfunction

  assign o_stat.state = state;
  assign o_stat.reset_active = (state == lsbwd_pkg::WDT_RESET);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= lsbwd_pkg::WDT_OFF;
      cnt <= '0;
      o_ev <= '0;
    end else begin
      o_ev <= '0;
      if (!i_run) begin
        state <= lsbwd_pkg::WDT_OFF;
        cnt <= '0;
      end else begin
        case (state)
          lsbwd_pkg::WDT_OFF: begin
            state <= lsbwd_pkg::WDT_LEAD;
            cnt <= '0;
          end
          lsbwd_pkg::WDT_LEAD: begin
            if (i_trig_fall) begin
              state <= lsbwd_pkg::WDT_CLOSED;
              cnt <= '0;
            end else if (i_tick) begin
              if (at_end(cnt, LEAD_OSC)) begin
                state <= lsbwd_pkg::WDT_RESET;
                cnt <= '0;
                o_ev.timeout <= 1'b1;
              end else begin
                cnt <= cnt + CW'(1);
              end
            end
          end
          lsbwd_pkg::WDT_CLOSED: begin
            if (i_trig_fall) begin
              state <= lsbwd_pkg::WDT_RESET;
              cnt <= '0;
              o_ev.early <= 1'b1;
            end else if (i_tick) begin
              if (at_end(cnt, CLOSED_OSC)) begin
                state <= lsbwd_pkg::WDT_OPEN;
                cnt <= '0;
              end else begin
                cnt <= cnt + CW'(1);
              end
            end
          end
          lsbwd_pkg::WDT_OPEN: begin
            if (i_trig_fall) begin
              state <= lsbwd_pkg::WDT_CLOSED;
              cnt <= '0;
            end else if (i_tick) begin
              if (at_end(cnt, OPEN_OSC)) begin
                state <= lsbwd_pkg::WDT_RESET;
                cnt <= '0;
                o_ev.timeout <= 1'b1;
              end else begin
                cnt <= cnt + CW'(1);
              end
            end
          end
          lsbwd_pkg::WDT_RESET: begin
            if (i_tick) begin
              if (at_end(cnt, RSTPULSE_OSC)) begin
                state <= lsbwd_pkg::WDT_LEAD;
                cnt <= '0;
              end else begin
                cnt <= cnt + CW'(1);
              end
            end
          end
          default: begin
            state <= lsbwd_pkg::WDT_OFF;
            cnt <= '0;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/lsbwd_top.sv ***
/*
  Operating mode, window watchdog and transceiver gating of a LIN basis chip,
  with an Avalon-MM register slave and one level interrupt.
  Assumes all pin inputs are synchronous to I_MCLK; open-drain pins are
  resolved outside from their output enables, with pull-ups outside too.
*/
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
// What this block does
// - At power-up the chip sits in fail-safe mode before any command.
// - Enable pin high moves fail-safe mode to normal mode unless a watchdog reset is active.
// - Only a falling trigger edge counts as a watchdog trigger.
// - No trigger in the open window drives the reset pin low.
// - Watchdog is halted in silent and sleep modes.
// - No trigger after start gives a reset when lead time ends.
// - All watchdog intervals count watchdog oscillator periods.
// - Oscillator period derives from the timing resistor; it is a parameter.
// - Triggers in the closed window are errors and cause a reset.
// - Unconnected trigger reads high and never yields a false edge.
// - Transceiver path works only in normal mode.
// - Normal mode copies transmit data to bus and bus to receive output.
// - Transmit high leaves bus recessive; low drives it dominant.
// - Transmit held low past the timeout is forced high internally.
`timescale 1ns/1ps
`default_nettype none

module lsbwd_top #(
  parameter int unsigned WDT_OSC_CYC = lsbwd_pkg::WDT_OSC_CYC,
  parameter int unsigned LEAD_OSC = lsbwd_pkg::LEAD_OSC,
  parameter int unsigned CLOSED_OSC = lsbwd_pkg::CLOSED_OSC,
  parameter int unsigned OPEN_OSC = lsbwd_pkg::OPEN_OSC,
  parameter int unsigned RSTPULSE_OSC = lsbwd_pkg::RSTPULSE_OSC,
  parameter int unsigned DOM_CYC = lsbwd_pkg::DOM_CYC
) (
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  input wire logic [7:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  output logic O_IRQ,
  input wire logic I_ENABLE,
  input wire logic I_WATCHDOG_TRIGGER_N,
  input wire logic I_RESET_OUT_N,
  output logic O_RESET_OUT_N,
  output logic O_RESET_OUT_N_OE,
  input wire logic I_TXD,
  output logic O_RXD,
  input wire logic I_LIN,
  output logic O_LIN,
  output logic O_LIN_OE
);

  localparam int DW = $clog2(DOM_CYC + 1);
  localparam logic [DW-1:0] DOM_LAST = DW'(DOM_CYC - 1);

  if (DOM_CYC < 1) begin : g_bad_dom
    $error("lsbwd_top: DOM_CYC must be at least 1");
  end

  // ********************************************************
  // Declarations
  // ********************************************************
  lsbwd_pkg::lsbwd_mode_t mode;
  lsbwd_pkg::lsbwd_mode_t next_mode;
  lsbwd_pkg::lsbwd_wdt_stat_t wdt_stat;
  lsbwd_pkg::lsbwd_wdt_ev_t wdt_ev;
  logic wdt_run;
  logic osc_tick;
  logic last_trig;
  logic trig_fall;
  logic wake_req;
  logic [DW-1:0] dom_cnt;
  logic txd_forced;
  logic dom_ev;
  logic [lsbwd_pkg::EV_W-1:0] irq_status;
  logic [lsbwd_pkg::EV_W-1:0] next_irq_status;
  logic [lsbwd_pkg::EV_W-1:0] irq_enable;
  logic [lsbwd_pkg::EV_W-1:0] events;
  logic bus_req;
  logic wr_go;
  logic rd_go;
  logic [31:0] rd_mux;

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ********************************************************
  // Trigger edge detection
  // ********************************************************
  // idle level high
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      last_trig <= 1'b1;
    end else begin
      last_trig <= I_WATCHDOG_TRIGGER_N;
    end
  end

  assign trig_fall = last_trig & ~I_WATCHDOG_TRIGGER_N;

  // ********************************************************
  // Mode sequencer
  // ********************************************************
  always_comb begin
    next_mode = mode;
    case (mode)
      lsbwd_pkg::MODE_FAILSAFE: begin
        if (I_ENABLE && !wdt_stat.reset_active) begin
          next_mode = lsbwd_pkg::MODE_NORMAL;
        end
      end
      lsbwd_pkg::MODE_NORMAL: begin
        if (wdt_stat.reset_active) begin
          next_mode = lsbwd_pkg::MODE_FAILSAFE;
        end else if (!I_ENABLE) begin
          next_mode = I_TXD ? lsbwd_pkg::MODE_SLEEP : lsbwd_pkg::MODE_SILENT;
        end
      end
      lsbwd_pkg::MODE_SILENT, lsbwd_pkg::MODE_SLEEP: begin
        if (wake_req) begin
          next_mode = lsbwd_pkg::MODE_FAILSAFE;
        end
      end
      default: begin
        next_mode = lsbwd_pkg::MODE_FAILSAFE;
      end
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      mode <= lsbwd_pkg::MODE_FAILSAFE;
    end else begin
      mode <= next_mode;
    end
  end

  assign wdt_run = (mode == lsbwd_pkg::MODE_FAILSAFE) || (mode == lsbwd_pkg::MODE_NORMAL);

  // ********************************************************
  // Watchdog
  // ********************************************************
  lsbwd_tick #(
    .DIV(WDT_OSC_CYC)
  ) u_tick (
    .i_clk(I_MCLK),
    .i_rst_n(I_RSTN),
    .i_run(wdt_run),
    .o_tick(osc_tick)
  );

  lsbwd_wdt #(
    .LEAD_OSC(LEAD_OSC),
    .CLOSED_OSC(CLOSED_OSC),
    .OPEN_OSC(OPEN_OSC),
    .RSTPULSE_OSC(RSTPULSE_OSC),
    .CW(16)
  ) u_wdt (
    .i_clk(I_MCLK),
    .i_rst_n(I_RSTN),
    .i_run(wdt_run),
    .i_tick(osc_tick),
    .i_trig_fall(trig_fall),
    .o_stat(wdt_stat),
    .o_ev(wdt_ev)
  );

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_RESET_OUT_N <= 1'b0;
      O_RESET_OUT_N_OE <= 1'b0;
    end else begin
      O_RESET_OUT_N <= 1'b0;
      O_RESET_OUT_N_OE <= wdt_stat.reset_active;
    end
  end

  // ********************************************************
  // Transceiver
  // ********************************************************
  // The timer keeps the bus free even if the transmit line is stuck low;
  // the force holds until the transmit input returns high or the mode leaves normal mode.
  // dominant timeout
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      dom_cnt <= '0;
      txd_forced <= 1'b0;
      dom_ev <= 1'b0;
    end else begin
      dom_ev <= 1'b0;
      if (I_TXD || mode != lsbwd_pkg::MODE_NORMAL) begin
        dom_cnt <= '0;
        txd_forced <= 1'b0;
      end else if (!txd_forced) begin
        if (dom_cnt == DOM_LAST) begin
          txd_forced <= 1'b1;
          dom_ev <= 1'b1;
        end else begin
          dom_cnt <= dom_cnt + DW'(1);
        end
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_LIN <= 1'b0;
      O_LIN_OE <= 1'b0;
      O_RXD <= 1'b1;
    end else begin
      O_LIN <= 1'b0;
      O_LIN_OE <= (next_mode == lsbwd_pkg::MODE_NORMAL) && !I_TXD && !txd_forced;
      O_RXD <= (mode == lsbwd_pkg::MODE_NORMAL) ? I_LIN : 1'b1;
    end
  end

  // ********************************************************
  // Avalon-MM slave
  // ********************************************************
  assign bus_req = I_AVS_READ | I_AVS_WRITE;
  assign wr_go = I_AVS_WRITE & ~O_AVS_WAITREQUEST;
  assign rd_go = bus_req & O_AVS_WAITREQUEST;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (is_reg(I_AVS_ADDRESS, lsbwd_pkg::REG_STATUS)) begin
      rd_mux[lsbwd_pkg::STATUS_MODE_LSB +: 4] = mode;
      rd_mux[lsbwd_pkg::STATUS_WDT_LSB +: 5] = wdt_stat.state;
      rd_mux[lsbwd_pkg::STATUS_PIN_BIT] = I_RESET_OUT_N;
      rd_mux[lsbwd_pkg::STATUS_TXDF_BIT] = txd_forced;
    end else if (is_reg(I_AVS_ADDRESS, lsbwd_pkg::REG_IRQ_STATUS)) begin
      rd_mux[lsbwd_pkg::EV_W-1:0] = irq_status;
    end else if (is_reg(I_AVS_ADDRESS, lsbwd_pkg::REG_IRQ_ENABLE)) begin
      rd_mux[lsbwd_pkg::EV_W-1:0] = irq_enable;
    end
  end

  // One wait state: the answer edge is the second edge of every request.
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_AVS_WAITREQUEST <= 1'b1;
      O_AVS_READDATA <= 32'h0000_0000;
    end else begin
      O_AVS_WAITREQUEST <= ~rd_go;
      if (rd_go && I_AVS_READ) begin
        O_AVS_READDATA <= rd_mux;
      end
    end
  end

  assign wake_req = wr_go && I_AVS_BYTEENABLE[0]
    && is_reg(I_AVS_ADDRESS, lsbwd_pkg::REG_CTRL)
    && I_AVS_WRITEDATA[lsbwd_pkg::CTRL_WAKE_BIT];

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      irq_enable <= lsbwd_pkg::IRQ_RESET;
    end else if (wr_go && I_AVS_BYTEENABLE[0]
                 && is_reg(I_AVS_ADDRESS, lsbwd_pkg::REG_IRQ_ENABLE)) begin
      irq_enable <= I_AVS_WRITEDATA[lsbwd_pkg::EV_W-1:0];
    end
  end

  // ********************************************************
  // Interrupts
  // ********************************************************
  always_comb begin
    events = '0;
    events[lsbwd_pkg::EV_TIMEOUT] = wdt_ev.timeout;
    events[lsbwd_pkg::EV_EARLY] = wdt_ev.early;
    events[lsbwd_pkg::EV_DOM] = dom_ev;
    next_irq_status = irq_status;
    if (wr_go && I_AVS_BYTEENABLE[0] && is_reg(I_AVS_ADDRESS, lsbwd_pkg::REG_IRQ_CLEAR)) begin
      next_irq_status = irq_status & ~I_AVS_WRITEDATA[lsbwd_pkg::EV_W-1:0];
    end
    // A new event outranks a clear arriving in the same cycle.
    next_irq_status = next_irq_status | events;
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      irq_status <= lsbwd_pkg::IRQ_RESET;
      O_IRQ <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      O_IRQ <= |(next_irq_status & irq_enable);
    end
  end

endmodule

`default_nettype wire

// *** sim/lsbwd_mcu_model.sv ***
/*
  Behavioural model of the controller at the far side of the block.
  Assumes the bench sets the trigger period; zero leaves the trigger open.
*/
`timescale 1ns/1ps
`default_nettype none
module lsbwd_mcu_model (
  input wire logic i_clk,
  input wire logic [7:0] i_period,
  input wire logic i_other_low,
  input wire logic i_reset_oe,
  input wire logic i_reset_val,
  input wire logic i_lin_oe,
  input wire logic i_lin_val,
  output logic o_trig_n,
  output logic o_reset_wire,
  output logic o_lin_wire
);
  logic [7:0] cnt;
  // ********************************************************
  // Open-drain wires with pull-ups
  // ********************************************************
  assign o_reset_wire = i_reset_oe ? i_reset_val : 1'b1;
  assign o_lin_wire = (i_lin_oe ? i_lin_val : 1'b1) & ~i_other_low;
  // ********************************************************
  // Trigger pulses
  // ********************************************************
  // periodic falling edge
  always_ff @(posedge i_clk) begin
    if (!o_reset_wire || i_period == 8'h00) begin
      cnt <= 8'h02;
    end else if (cnt >= i_period - 8'h01) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
  assign o_trig_n = !o_reset_wire || i_period == 8'h00 || cnt > 8'h01;
endmodule
`default_nettype wire

// *** sim/lsbwd_properties.sv ***
/*
  Port-level checks of the mode and watchdog block.
  Assumes one clock domain; attached by the bind at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module lsbwd_properties #(
  parameter int unsigned WDT_OSC_CYC = 392,
  parameter int unsigned RSTPULSE_OSC = 200,
  parameter int unsigned DOM_CYC = 200000
) (
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic I_ENABLE,
  input wire logic I_TXD,
  input wire logic I_LIN,
  input wire logic O_RXD,
  input wire logic O_LIN,
  input wire logic O_LIN_OE,
  input wire logic O_RESET_OUT_N,
  input wire logic O_RESET_OUT_N_OE
);
  // Tick phase is unknown, so the pulse may be one period short.
  localparam int PLO = (RSTPULSE_OSC - 1) * WDT_OSC_CYC + 1;
  localparam int PHI = RSTPULSE_OSC * WDT_OSC_CYC + 1;
  int hi_cnt;
  int low_cnt;
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      hi_cnt <= 0;
      low_cnt <= 0;
    end else begin
      hi_cnt <= O_RESET_OUT_N_OE ? hi_cnt + 1 : 0;
      low_cnt <= I_TXD ? 0 : (low_cnt > int'(DOM_CYC) + 2 ? low_cnt : low_cnt + 1);
    end
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);
  sequence s_taken;
    (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
  endsequence
  sequence s_answer;
    !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
  endsequence
  a_bus_answer: assert property (s_taken |=> s_answer)
    else $error("Bus answer not one cycle after request");
  a_wait_single: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("Wait request low for more than one cycle");
  a_lin_follows_txd: assert property (O_LIN_OE |-> !$past(I_TXD))
    else $error("Bus driven dominant with transmit input high");
  a_rxd_from_bus: assert property (!O_RXD |-> !$past(I_LIN))
    else $error("Receive output low without a dominant bus");
  a_lin_off_enable: assert property (!$past(I_ENABLE) |-> !O_LIN_OE)
    else $error("Bus driven outside normal mode");
  a_lin_off_reset: assert property ($rose(O_RESET_OUT_N_OE) |-> !O_LIN_OE)
    else $error("Bus driven while reset starts");
  a_pulse_length: assert property ($fell(O_RESET_OUT_N_OE) |-> hi_cnt inside {[PLO:PHI]})
    else $error("Reset pulse length wrong");
  a_dom_release: assert property (low_cnt > int'(DOM_CYC) + 1 |-> !O_LIN_OE)
    else $error("Bus still dominant after the timeout");
  a_pins_low: assert property (!O_RESET_OUT_N && !O_LIN)
    else $error("Open-drain output value not low");
endmodule
bind lsbwd_top lsbwd_properties #(
  .WDT_OSC_CYC(WDT_OSC_CYC), .RSTPULSE_OSC(RSTPULSE_OSC), .DOM_CYC(DOM_CYC)
) props_u (
  .I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_ENABLE(I_ENABLE), .I_TXD(I_TXD), .I_LIN(I_LIN),
  .O_RXD(O_RXD), .O_LIN(O_LIN), .O_LIN_OE(O_LIN_OE), .O_RESET_OUT_N(O_RESET_OUT_N),
  .O_RESET_OUT_N_OE(O_RESET_OUT_N_OE)
);
`default_nettype wire

// *** sim/tb_top.sv ***
/*
  Self-checking bench of the mode and watchdog block with shortened counts.
  Assumes the controller model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  localparam int OC = 2;
  localparam int LD = 20;
  localparam int CL = 5;
  localparam int OP = 5;
  localparam int DC = 50;
  logic mclk, rstn, rd, wr, en, txd, other_low, waitreq, irq, rst_oe, rst_val, last_oe;
  logic rxd, lin_val, lin_oe, trig_n, rst_wire, lin_wire;
  logic [7:0] addr, period;
  logic [31:0] wdata, q, rdata;
  logic [3:0] be;
  int fail_count, n_tests, cyc, cyc0, n_rst, m;
  lsbwd_top #(.WDT_OSC_CYC(OC), .LEAD_OSC(LD), .CLOSED_OSC(CL), .OPEN_OSC(OP),
    .RSTPULSE_OSC(3), .DOM_CYC(DC)) dut_u (
    .I_MCLK(mclk), .I_RSTN(rstn), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
    .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(waitreq), .O_IRQ(irq), .I_ENABLE(en), .I_WATCHDOG_TRIGGER_N(trig_n),
    .I_RESET_OUT_N(rst_wire), .O_RESET_OUT_N(rst_val), .O_RESET_OUT_N_OE(rst_oe),
    .I_TXD(txd), .O_RXD(rxd), .I_LIN(lin_wire), .O_LIN(lin_val), .O_LIN_OE(lin_oe));
  lsbwd_mcu_model mcu_u (.i_clk(mclk), .i_period(period), .i_other_low(other_low),
    .i_reset_oe(rst_oe), .i_reset_val(rst_val), .i_lin_oe(lin_oe), .i_lin_val(lin_val),
    .o_trig_n(trig_n), .o_reset_wire(rst_wire), .o_lin_wire(lin_wire));
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    last_oe <= rst_oe;
    if (rst_oe === 1'b1 && last_oe !== 1'b1) n_rst <= n_rst + 1;
    if (cyc == 5000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // The request is held until wait request is seen low at an edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    rd <= !w; wr <= w; addr <= a; wdata <= d; be <= 4'hF;
    do @(posedge mclk); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q & mk, e)
  endtask
  task automatic wcyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wait_oe(input logic v, input int lim);
    int n;
    n = 0;
    while (rst_oe !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic t_after_reset();
    rdchk(lsbwd_pkg::REG_STATUS, 32'hFFFFFFFF, 32'h00000221);
    rdchk(lsbwd_pkg::REG_IRQ_STATUS, 32'hFFFFFFFF, 32'h0);
    rdchk(8'h14, 32'hFFFFFFFF, 32'h0);
    @(posedge mclk);
    rd <= 1'b0; wr <= 1'b1; addr <= lsbwd_pkg::REG_IRQ_ENABLE; wdata <= 32'h7; be <= 4'hE;
    do @(posedge mclk); while (waitreq !== 1'b0);
    wr <= 1'b0;
    rdchk(lsbwd_pkg::REG_IRQ_ENABLE, 32'hFFFFFFFF, 32'h0);
  endtask
  task automatic t_lead();
    wait_oe(1'b1, 100);
    `CHK((cyc - cyc0) inside {[LD*OC-OC:LD*OC+OC+6]}, 1'b1)
    rdchk(lsbwd_pkg::REG_IRQ_STATUS, 32'h1, 32'h1);
  endtask
  task automatic t_normal();
    en <= 1'b1;
    period <= 8'd14;
    wait_oe(1'b0, 50);
    wcyc(3);
    rdchk(lsbwd_pkg::REG_STATUS, 32'hF, 32'h2);
    bus(1'b1, lsbwd_pkg::REG_IRQ_ENABLE, 32'h1);
    wcyc(2);
    `CHK(irq, 1'b1)
    bus(1'b1, lsbwd_pkg::REG_IRQ_ENABLE, 32'h0);
    wcyc(2);
    `CHK(irq, 1'b0)
    bus(1'b1, lsbwd_pkg::REG_IRQ_ENABLE, 32'h1);
    bus(1'b1, lsbwd_pkg::REG_IRQ_CLEAR, 32'h1);
    wcyc(2);
    `CHK(irq, 1'b0)
    m = n_rst;
    wcyc(150);
    `CHK(n_rst, m)
  endtask
  task automatic t_trans();
    txd <= 1'b0;
    wcyc(3);
    `CHK(lin_wire, 1'b0)
    `CHK(rxd, 1'b0)
    txd <= 1'b1;
    wcyc(3);
    `CHK(lin_oe, 1'b0)
    other_low <= 1'b1;
    wcyc(3);
    `CHK(rxd, 1'b0)
    other_low <= 1'b0;
    txd <= 1'b0;
    wcyc(DC + 5);
    `CHK(lin_oe, 1'b0)
    rdchk(lsbwd_pkg::REG_IRQ_STATUS, 32'h4, 32'h4);
    rdchk(lsbwd_pkg::REG_STATUS, 32'h400, 32'h400);
    txd <= 1'b1;
  endtask
  task automatic t_windows();
    period <= 8'd4;
    wait_oe(1'b1, 60);
    `CHK(rst_oe, 1'b1)
    rdchk(lsbwd_pkg::REG_IRQ_STATUS, 32'h2, 32'h2);
    period <= 8'd14;
    wait_oe(1'b0, 50);
    wcyc(60);
    period <= 8'd0;
    wait_oe(1'b1, (CL + OP) * OC + 8);
    `CHK(rst_oe, 1'b1)
    rdchk(lsbwd_pkg::REG_IRQ_STATUS, 32'h1, 32'h1);
  endtask
  task automatic t_modes();
    wait_oe(1'b0, 50);
    wcyc(2);
    txd <= 1'b0;
    en <= 1'b0;
    wcyc(2);
    rdchk(lsbwd_pkg::REG_STATUS, 32'h1FF, 32'h014);
    other_low <= 1'b1;
    period <= 8'd4;
    m = n_rst;
    wcyc(100);
    `CHK(n_rst, m)
    `CHK(rxd, 1'b1)
    period <= 8'd0;
    other_low <= 1'b0;
    txd <= 1'b1;
    bus(1'b1, lsbwd_pkg::REG_CTRL, 32'h1);
    rdchk(lsbwd_pkg::REG_STATUS, 32'h1FF, 32'h021);
    en <= 1'b1;
    wcyc(3);
    en <= 1'b0;
    wcyc(2);
    rdchk(lsbwd_pkg::REG_STATUS, 32'h1FF, 32'h018);
    bus(1'b1, lsbwd_pkg::REG_CTRL, 32'h1);
    txd <= 1'b0;
    wcyc(3);
    `CHK(lin_oe, 1'b0)
  endtask
  initial begin
    mclk = 1'b0; rstn = 1'b0; rd = 1'b0; wr = 1'b0; addr = 8'h00; wdata = 32'h0;
    be = 4'h0; en = 1'b0; txd = 1'b1; other_low = 1'b0; period = 8'h00; last_oe = 1'b0;
    fail_count = 0; n_tests = 0; cyc = 0; n_rst = 0; m = 0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    cyc0 = cyc;
    t_after_reset();
    t_lead();
    t_normal();
    t_trans();
    t_windows();
    t_modes();
    complete_run();
  end
endmodule
`default_nettype wire
